/* logic/wdg_pkg.sv */
package wdg_pkg;
  localparam logic [7:0] WDG_ADDR_COUNT_CONTROL = 8'hD8;
  localparam logic [7:0] WDG_ADDR_OPTIONS = 8'hDC;
  localparam logic [7:0] WDG_RESET_VALUE = 8'hFE;
  localparam int WDG_BIT_ACTIVE = 0;
  localparam int WDG_BIT_SOFT_RESET = 1;
  localparam int WDG_PRESCALE_CYCLES = 3072;
  localparam logic [11:0] WDG_PRESCALE_LAST = 12'hBFF;
  localparam int WDG_POR_DELAY_CYCLES = 2048;
  localparam logic [11:0] WDG_POR_LAST = 12'h7FF;
  localparam logic [31:0] WDG_RDATA_ZERO = 32'h0000_0000;
  typedef enum logic [1:0] {
    WDG_RUN,
    WDG_WAIT,
    WDG_STOP
  } wdg_power_t;
endpackage : wdg_pkg

/* logic/wdg_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module wdg_sync (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic i_async,
  output logic o_sync
);
  logic meta_reg;
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      meta_reg <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end
endmodule : wdg_sync
`default_nettype wire

/* logic/wdg_reset_stretch.sv */
`timescale 1ns/1ps
`default_nettype none
module wdg_reset_stretch
  import wdg_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic i_trigger,
  output logic o_chip_reset
);
  logic [11:0] delay_reg;
  logic hold_reg;
  // Source still high keeps delay at zero; release then counts 2048 cycles
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      delay_reg <= 12'h000;
      hold_reg <= 1'b1;
    end else if (i_trigger) begin
      delay_reg <= 12'h000;
      hold_reg <= 1'b1;
    end else if (hold_reg) begin
      if (delay_reg == WDG_POR_LAST) begin
        hold_reg <= 1'b0;
      end else begin
        delay_reg <= delay_reg + 12'h001;
      end
    end
  end
  assign o_chip_reset = hold_reg | i_trigger;
endmodule : wdg_reset_stretch
`default_nettype wire

/* logic/wdg_top.sv */
// Notes on behaviour
// - Activated counter reaching the end count asserts chip reset.
// - Software option: inactive until software writes the activation bit one.
// - Activation cannot be undone by writes; only chip reset clears it.
// - While inactive, true STOP with oscillator halted is allowed.
// - Hardware option: activation bit 0 reads one and ignores writes.
// - Hardware option without external stop control: STOP behaves as WAIT.
// - External stop control while active: NMI low gives WAIT, NMI high freezes and stops.
// - Leaving STOP on interrupt resumes counting from the held value.
// - Reset loads FEh: active clear, soft reset and countdown bits set.
// - Soft reset bit 1 becoming zero triggers immediate chip reset.
// - Register bit 7 is counter LSB, register bit 2 counter bit 5.
// - Counter bit 6 falling to zero triggers reset.
// - Sixty-four periods from 3072 to 196608 clock cycles.
// - Inactive: free 7-bit down timer, soft reset bit is MSB, no reset.
// - At least 28 instructions run before a reset can occur.
// - Watchdog reset restarts exactly like pin reset, with delay.
// - Internal reset held 2048 cycles after source released.
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module wdg_top
  import wdg_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  input wire logic I_RESET_PIN_N,
  input wire logic I_NMI,
  input wire logic I_STOP_REQ,
  input wire logic I_WAIT_REQ,
  input wire logic I_WAKE_IRQ,
  output logic O_CHIP_RESET,
  output logic O_OSC_ENABLE,
  output logic O_CPU_STOPPED,
  output logic O_CPU_WAITING
);
  import wdg_pkg::*;

  logic nmi_s;
  logic pin_n_s;
  logic [7:0] ctrl_reg;
  logic [11:0] presc_reg;
  logic [1:0] opt_reg;
  logic opt_hw;
  logic opt_ext_stop;
  logic active;
  logic [6:0] count;
  logic [6:0] count_next;
  logic [7:0] wr_value;
  logic tick;
  logic expire;
  logic soft_reset;
  logic trigger;
  logic chip_reset;
  wdg_power_t power_reg;
  logic frozen;
  logic ph_valid_reg;
  logic ph_write_reg;
  logic [7:0] ph_addr_reg;
  logic bus_wr;
  logic [7:0] wr_byte;
  logic [7:0] ctrl_next;
  logic [7:0] counted;
  logic [7:0] ctrl_view;
  logic [31:0] rdata_next;
  logic [11:0] presc_next;
  logic [1:0] opt_next;
  logic addr_req;
  logic rd_req;
  logic wr_ctrl;
  logic wr_opt;
  logic stop_true;
  wdg_power_t power_next;

  // Pins cross into the clock domain first
  wdg_sync u_sync_nmi (
    .I_CLK(I_CLK),
    .I_RST(I_RST),
    .i_async(I_NMI),
    .o_sync(nmi_s)
  );

  wdg_sync u_sync_pin (
    .I_CLK(I_CLK),
    .I_RST(1'b0),
    .i_async(I_RESET_PIN_N),
    .o_sync(pin_n_s)
  );

  // Options: bit0 hardware activation, bit1 external stop control
  // Writable only inside the reset stretch, so running code cannot change them
  always_comb begin
    opt_next = opt_reg;
    if (wr_opt && chip_reset) begin
      opt_next = wr_byte[1:0];
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      opt_reg <= 2'h0;
    end else begin
      opt_reg <= opt_next;
    end
  end
  assign opt_hw = opt_reg[0];
  assign opt_ext_stop = opt_reg[1];

  // AHB-Lite address phase capture
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      ph_valid_reg <= 1'b0;
      ph_write_reg <= 1'b0;
      ph_addr_reg <= 8'h00;
    end else if (I_HREADY) begin
      ph_valid_reg <= I_HSEL & I_HTRANS[1];
      ph_write_reg <= I_HWRITE;
      ph_addr_reg <= I_HADDR[7:0];
    end
  end
  assign bus_wr = ph_valid_reg & ph_write_reg;
  assign wr_byte = I_HWDATA[7:0];
  assign wr_ctrl = bus_wr && (ph_addr_reg == WDG_ADDR_COUNT_CONTROL);
  assign wr_opt = bus_wr && (ph_addr_reg == WDG_ADDR_OPTIONS);
  assign addr_req = I_HREADY & I_HSEL & I_HTRANS[1];
  assign rd_req = addr_req & !I_HWRITE;
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP = 1'b0;

  // Next-state values, so a read straight after a write sees the new value
  always_comb begin
    case (I_HADDR[7:0])
      WDG_ADDR_COUNT_CONTROL: begin
        rdata_next = {24'h000000, ctrl_view};
      end
      WDG_ADDR_OPTIONS: begin
        rdata_next = {30'h0, opt_next};
      end
      default: begin
        rdata_next = WDG_RDATA_ZERO;
      end
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_HRDATA <= WDG_RDATA_ZERO;
    end else if (rd_req) begin
      O_HRDATA <= rdata_next;
    end
  end

  // Counter view: bit6 is soft reset, bits5..0 reversed from register
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_map
      assign count[g] = ctrl_reg[7 - g];
    end
  endgenerate
  assign count[6] = ctrl_reg[WDG_BIT_SOFT_RESET];
  assign active = opt_hw | ctrl_reg[WDG_BIT_ACTIVE];

  assign count_next = count - 7'h01;
  assign frozen = (power_reg == WDG_STOP);
  assign tick = (presc_reg == WDG_PRESCALE_LAST) && !frozen;

  // Held while frozen so a wake resumes mid-period, not from a fresh period
  always_comb begin
    presc_next = presc_reg;
    if (chip_reset || bus_wr) begin
      presc_next = 12'h000;
    end else if (tick) begin
      presc_next = 12'h000;
    end else if (!frozen) begin
      presc_next = presc_reg + 12'h001;
    end
  end

  always_ff @(posedge I_CLK) begin
    presc_reg <= presc_next;
  end

  // Write value: activation bit sticky, never cleared by software
  always_comb begin
    wr_value = wr_byte;
    wr_value[WDG_BIT_ACTIVE] = wr_byte[WDG_BIT_ACTIVE] | ctrl_reg[WDG_BIT_ACTIVE];
  end

  // Decremented count laid back into register bit order
  generate
    for (g = 0; g < 6; g++) begin : g_unmap
      assign counted[7 - g] = count_next[g];
    end
  endgenerate
  assign counted[WDG_BIT_SOFT_RESET] = count_next[6];
  assign counted[WDG_BIT_ACTIVE] = ctrl_reg[WDG_BIT_ACTIVE];

  // Reload beats the tick in one cycle; free 7-bit timer wraps when inactive
  always_comb begin
    ctrl_next = ctrl_reg;
    if (chip_reset) begin
      ctrl_next = WDG_RESET_VALUE;
    end else if (wr_ctrl) begin
      ctrl_next = wr_value;
    end else if (tick) begin
      ctrl_next = counted;
    end
  end
  assign ctrl_view = {ctrl_next[7:1], ctrl_next[WDG_BIT_ACTIVE] | opt_hw};

  always_ff @(posedge I_CLK) begin
    ctrl_reg <= ctrl_next;
  end

  // Reset when soft reset bit reads zero while active
  assign soft_reset = active & !ctrl_reg[WDG_BIT_SOFT_RESET];
  assign expire = soft_reset;
  // Minimum first period is 3072 cycles, far beyond 28 instructions
  assign trigger = expire | !pin_n_s | I_RST;

  wdg_reset_stretch u_stretch (
    .I_CLK(I_CLK),
    .I_RST(1'b0),
    .i_trigger(trigger),
    .o_chip_reset(chip_reset)
  );
  assign O_CHIP_RESET = chip_reset;

  // True STOP only when nothing needs the clock
  assign stop_true = !active | (opt_ext_stop & nmi_s);

  // Power mode next state on STOP, WAIT and wake
  always_comb begin
    power_next = power_reg;
    unique case (power_reg)
      WDG_RUN: begin
        if (I_STOP_REQ) begin
          if (stop_true) begin
            power_next = WDG_STOP;
          end else begin
            power_next = WDG_WAIT;
          end
        end else if (I_WAIT_REQ) begin
          power_next = WDG_WAIT;
        end
      end
      WDG_WAIT: begin
        if (I_WAKE_IRQ) begin
          power_next = WDG_RUN;
        end
      end
      WDG_STOP: begin
        if (I_WAKE_IRQ) begin
          power_next = WDG_RUN;
        end
      end
      default: begin
        power_next = WDG_RUN;
      end
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (chip_reset) begin
      power_reg <= WDG_RUN;
    end else begin
      power_reg <= power_next;
    end
  end

  // Oscillator must keep running whenever counting is needed
  assign O_OSC_ENABLE = (power_reg != WDG_STOP) | chip_reset;
  assign O_CPU_STOPPED = (power_reg == WDG_STOP);
  assign O_CPU_WAITING = (power_reg == WDG_WAIT);
endmodule : wdg_top
`default_nettype wire

/* dv/wdg_top_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module wdg_checker
  import wdg_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  input wire logic I_WAKE_IRQ,
  input wire logic O_HREADYOUT,
  input wire logic O_HRESP,
  input wire logic O_CHIP_RESET,
  input wire logic O_OSC_ENABLE,
  input wire logic O_CPU_STOPPED,
  input wire logic O_CPU_WAITING
);
  logic wr_ph;
  logic [11:0] hi_cnt;
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  always_ff @(posedge I_CLK) begin
    wr_ph <= !I_RST && I_HREADY && I_HSEL && I_HTRANS[1] && I_HWRITE
      && I_HADDR[7:0] == WDG_ADDR_COUNT_CONTROL;
  end
  // Saturates so a long pin reset cannot wrap it
  always_ff @(posedge I_CLK) begin
    if (I_RST || !O_CHIP_RESET) hi_cnt <= 12'h000;
    else if (hi_cnt != 12'hFFF) hi_cnt <= hi_cnt + 12'h001;
  end
  hready_high_a: assert property (O_HREADYOUT) else $error("hreadyout low");
  resp_okay_a: assert property (!O_HRESP) else $error("error response");
  rst_forces_reset_a: assert property (disable iff (1'b0) I_RST |-> O_CHIP_RESET)
    else $error("reset input not passed on");
  reset_stretch_a: assert property ($fell(O_CHIP_RESET) |-> hi_cnt >= 12'h800)
    else $error("chip reset released early");
  stop_osc_off_a: assert property (O_CPU_STOPPED |-> !O_OSC_ENABLE)
    else $error("oscillator runs in stop");
  wait_osc_on_a: assert property (O_CPU_WAITING |-> O_OSC_ENABLE && !O_CPU_STOPPED)
    else $error("wait without oscillator");
  soft_clear_a: assert property (wr_ph && I_HWDATA[1:0] == 2'b01 |-> ##[0:2] O_CHIP_RESET)
    else $error("soft reset write ignored");
  wake_resume_a: assert property (O_CPU_STOPPED && I_WAKE_IRQ |-> ##[1:3] !O_CPU_STOPPED)
    else $error("no wake from stop");
  cover property ($fell(O_CHIP_RESET));
  cover property ($rose(O_CPU_STOPPED));
  cover property ($rose(O_CPU_WAITING));
endmodule : wdg_checker
`default_nettype wire

/* dv/wdg_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module wdg_cpu_model (
  input wire logic i_clk,
  input wire logic [1:0] i_cmd,
  input wire logic i_nmi_idle,
  output logic o_stop,
  output logic o_wait,
  output logic o_wake,
  output logic o_nmi
);
  logic [1:0] cmd_q = 2'h0;
  // One-cycle instruction pulses, like the core's decode
  always @(posedge i_clk) cmd_q <= i_cmd;
  assign o_stop = cmd_q == 2'h1;
  assign o_wait = cmd_q == 2'h2;
  assign o_wake = cmd_q == 2'h3;
  // Idle level high so stop stays available
  assign o_nmi = i_nmi_idle;
endmodule : wdg_cpu_model
`default_nettype wire

/* dv/digital_watchdog_downcounter_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module digital_watchdog_downcounter_tb;
  import wdg_pkg::*;
  logic clk, rst, hsel, hwrite, rdy, stp, wt, wk, nmi, nmi_idle;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, cmd;
  logic [7:0] rd;
  logic chip_rst, osc, stopped, waiting;
  int n_fail, n_checks;
  wdg_top dut_u (.I_CLK(clk), .I_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
    .I_HREADY(rdy), .O_HRDATA(hrdata), .O_HREADYOUT(rdy), .O_HRESP(),
    .I_RESET_PIN_N(1'b1), .I_NMI(nmi), .I_STOP_REQ(stp), .I_WAIT_REQ(wt),
    .I_WAKE_IRQ(wk), .O_CHIP_RESET(chip_rst), .O_OSC_ENABLE(osc),
    .O_CPU_STOPPED(stopped), .O_CPU_WAITING(waiting));
  wdg_cpu_model cpu_u (.i_clk(clk), .i_cmd(cmd), .i_nmi_idle(nmi_idle),
    .o_stop(stp), .o_wait(wt), .o_wake(wk), .o_nmi(nmi));
  task automatic results;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %0t seen %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin @(posedge clk); n++; end while (rdy !== 1'b1 && n < 20);
    if (n >= 20) begin n_fail++; results(); end
  endtask : wait_rdy
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    hsel <= 1'b1; htrans <= 2'b10; haddr <= {24'h0, a}; hwrite <= w;
    wait_rdy();
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= {24'h0, d};
    wait_rdy();
    rd = hrdata[7:0];
  endtask : bus
  task automatic wait_sig(input logic v, input int lim);
    int n;
    n = 0;
    while (chip_rst !== v && n < lim) begin @(posedge clk); n++; end
    check({7'h0, chip_rst}, {7'h0, v});
    if (n >= lim) results();
  endtask : wait_sig
  task automatic do_reset(input logic [7:0] opt);
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    bus(1'b1, WDG_ADDR_OPTIONS, opt);
    wait_sig(1'b0, 2200);
  endtask : do_reset
  task automatic cpu(input logic [1:0] c, input logic [7:0] exp);
    cmd <= c;
    @(posedge clk);
    cmd <= 2'h0;
    repeat (5) @(posedge clk);
    check({5'h0, stopped, waiting, osc}, exp);
  endtask : cpu
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    rst = 1'b1; hsel = 1'b0; haddr = '0; htrans = '0; hwrite = 1'b0; hwdata = '0;
    cmd = 2'h0; nmi_idle = 1'b1; n_fail = 0; n_checks = 0;
    do_reset(8'h00);
    bus(1'b0, WDG_ADDR_COUNT_CONTROL, 8'h0); check(rd, WDG_RESET_VALUE);
    bus(1'b0, 8'h40, 8'h0); check(rd, 8'h00);
    // Counter value 1: lowest count bit sits at register bit 7
    bus(1'b1, WDG_ADDR_COUNT_CONTROL, 8'h80);
    repeat (3000) @(posedge clk);
    bus(1'b0, WDG_ADDR_COUNT_CONTROL, 8'h0); check(rd, 8'h80);
    repeat (200) @(posedge clk);
    bus(1'b0, WDG_ADDR_COUNT_CONTROL, 8'h0); check(rd, 8'h00);
    repeat (3072) @(posedge clk);
    bus(1'b0, WDG_ADDR_COUNT_CONTROL, 8'h0); check(rd, 8'hFE);
    check({7'h0, chip_rst}, 8'h00);
    cpu(2'h1, 8'h04);
    cpu(2'h3, 8'h01);
    cpu(2'h2, 8'h03);
    cpu(2'h3, 8'h01);
    $display("inactive timer test done");
    bus(1'b1, WDG_ADDR_COUNT_CONTROL, 8'h03);
    bus(1'b1, WDG_ADDR_COUNT_CONTROL, 8'h02);
    bus(1'b0, WDG_ADDR_COUNT_CONTROL, 8'h0); check(rd, 8'h03);
    repeat (3000) @(posedge clk);
    check({7'h0, chip_rst}, 8'h00);
    wait_sig(1'b1, 200);
    wait_sig(1'b0, 2200);
    bus(1'b0, WDG_ADDR_COUNT_CONTROL, 8'h0); check(rd, WDG_RESET_VALUE);
    $display("timeout test done");
    bus(1'b1, WDG_ADDR_COUNT_CONTROL, 8'hFF);
    bus(1'b0, WDG_ADDR_COUNT_CONTROL, 8'h0);
    if (rd[0]) bus(1'b1, WDG_ADDR_COUNT_CONTROL, 8'hFD);
    wait_sig(1'b1, 3);
    wait_sig(1'b0, 2200);
    $display("soft reset test done");
    do_reset(8'h01);
    bus(1'b1, WDG_ADDR_COUNT_CONTROL, 8'hFE);
    bus(1'b0, WDG_ADDR_COUNT_CONTROL, 8'h0); check(rd, 8'hFF);
    bus(1'b1, WDG_ADDR_COUNT_CONTROL, 8'h02);
    repeat (3000) @(posedge clk);
    bus(1'b1, WDG_ADDR_COUNT_CONTROL, 8'h02);
    repeat (3000) @(posedge clk);
    check({7'h0, chip_rst}, 8'h00);
    bus(1'b1, WDG_ADDR_COUNT_CONTROL, 8'hFE);
    cpu(2'h1, 8'h03);
    cpu(2'h3, 8'h01);
    do_reset(8'h03);
    nmi_idle <= 1'b0;
    repeat (3) @(posedge clk);
    cpu(2'h1, 8'h03);
    cpu(2'h3, 8'h01);
    nmi_idle <= 1'b1;
    repeat (3) @(posedge clk);
    cpu(2'h1, 8'h04);
    repeat (3500) @(posedge clk);
    bus(1'b0, WDG_ADDR_COUNT_CONTROL, 8'h0); check(rd, 8'hFF);
    cpu(2'h3, 8'h01);
    repeat (3100) @(posedge clk);
    bus(1'b0, WDG_ADDR_COUNT_CONTROL, 8'h0); check(rd, 8'h7F);
    $display("option test done");
    results();
  end
endmodule : digital_watchdog_downcounter_tb
bind wdg_top wdg_checker chk_u (
  .I_CLK(I_CLK),
  .I_RST(I_RST),
  .I_HSEL(I_HSEL),
  .I_HADDR(I_HADDR),
  .I_HTRANS(I_HTRANS),
  .I_HWRITE(I_HWRITE),
  .I_HWDATA(I_HWDATA),
  .I_HREADY(I_HREADY),
  .I_WAKE_IRQ(I_WAKE_IRQ),
  .O_HREADYOUT(O_HREADYOUT),
  .O_HRESP(O_HRESP),
  .O_CHIP_RESET(O_CHIP_RESET),
  .O_OSC_ENABLE(O_OSC_ENABLE),
  .O_CPU_STOPPED(O_CPU_STOPPED),
  .O_CPU_WAITING(O_CPU_WAITING)
);
`default_nettype wire
